/* core/txo_pkg.sv */
// Purpose: constants and types for the transmit output stage
// Assumes: one system clock; latency figures counted in its cycles
// Notes: cosine table is 16 points, two's complement
package txo_pkg;
    localparam int IQ_W = 12;
    localparam int FTW_W = 26;
    localparam int NPROF = 4;
    localparam int PROF_W = 2;
    localparam int GAIN_W = 4;
    localparam int CA_W = 8;
    // ************************************************************
    // timing counts in system clock cycles
    // ************************************************************
    localparam int LAT_CYC = 119;
    localparam int SETTLE_CYC = 176;
    localparam int HOP_MAX_CYC = 232;
    localparam int PIPE_STAGES = 4;
    localparam int DLY_DEPTH = LAT_CYC - PIPE_STAGES;
    localparam logic [1:0] MCLK_HALF = 2'h1;
    localparam int CA_BIT_CYC = 4;
    localparam logic [4:0] CA_LAST = 5'(CA_W * CA_BIT_CYC - 1);
    // ************************************************************
    // datapath scaling
    // ************************************************************
    localparam logic [9:0] ATT_NUM = 10'h0B5;
    localparam int ATT_LSB = 8;
    localparam int MOD_LSB = 11;
    localparam int GAIN_LSB = 8;
    localparam logic [3:0] SIN_OFS = 4'h4;
    localparam logic signed [11:0] DAC_MAX = 12'sh7FF;
    localparam logic signed [11:0] DAC_MIN = -12'sh7FF;

    typedef struct packed {
        logic signed [IQ_W-1:0] i;
        logic signed [IQ_W-1:0] q;
    } txo_iq_t;

    typedef struct packed {
        logic en_b;
        logic clk;
        logic data;
    } txo_ca_t;

    typedef enum logic {CA_IDLE, CA_SHIFT} txo_ca_st_t;

    function automatic logic signed [11:0] txo_cos(input logic [3:0] p);
        case (p)
            4'h0: txo_cos = 12'h7FF;
            4'h1, 4'hF: txo_cos = 12'h763;
            4'h2, 4'hE: txo_cos = 12'h5A7;
            4'h3, 4'hD: txo_cos = 12'h30F;
            4'h5, 4'hB: txo_cos = 12'hCF1;
            4'h6, 4'hA: txo_cos = 12'hA59;
            4'h7, 4'h9: txo_cos = 12'h89D;
            4'h8: txo_cos = 12'h801;
            default: txo_cos = 12'h000;
        endcase
    endfunction : txo_cos

    // fine gain: 256 * 10^((-7.5 + 0.5 n) / 20)
    function automatic logic [9:0] txo_gain(input logic [3:0] n);
        case (n)
            4'h0: txo_gain = 10'h06C;
            4'h1: txo_gain = 10'h072;
            4'h2: txo_gain = 10'h079;
            4'h3: txo_gain = 10'h080;
            4'h4: txo_gain = 10'h088;
            4'h5: txo_gain = 10'h090;
            4'h6: txo_gain = 10'h099;
            4'h7: txo_gain = 10'h0A2;
            4'h8: txo_gain = 10'h0AB;
            4'h9: txo_gain = 10'h0B5;
            4'hA: txo_gain = 10'h0C0;
            4'hB: txo_gain = 10'h0CB;
            4'hC: txo_gain = 10'h0D7;
            4'hD: txo_gain = 10'h0E4;
            4'hE: txo_gain = 10'h0F2;
            default: txo_gain = 10'h100;
        endcase
    endfunction : txo_gain
endpackage : txo_pkg

/* core/txo_output_stage.sv */
// Purpose: transmit output stage from assembled I/Q to the DAC code
// Assumes: samples and profile select bits come from logic on sys_clk_i
// Notes: profile pin is asynchronous and passes three flip-flops
`timescale 1ns/10ps
module txo_output_stage (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic iq_valid_i,
    input wire txo_pkg::txo_iq_t iq_i,
    input wire logic prof_pin_i,
    input wire logic [txo_pkg::PROF_W-1:0] prof_sel_i,
    input wire logic [txo_pkg::NPROF-1:0][txo_pkg::FTW_W-1:0] carrier_ftw_i,
    input wire logic [txo_pkg::NPROF-1:0][txo_pkg::CA_W-1:0] ca_gain_i,
    input wire logic [txo_pkg::GAIN_W-1:0] fine_gain_i,
    output logic signed [txo_pkg::IQ_W-1:0] dac_code_o,
    output logic dac_stb_o,
    output logic mclk_o,
    output logic [txo_pkg::PROF_W-1:0] prof_o,
    output txo_pkg::txo_ca_t ca_o
);
    // ************************************************************
    // profile pin synchroniser and profile tracking
    // ************************************************************
    logic pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic [txo_pkg::PROF_W-1:0] prof_reg;
    logic [txo_pkg::FTW_W-1:0] ftw_reg, phase_reg;
    wire [txo_pkg::PROF_W-1:0] prof_want_w = prof_sel_i ^ {1'b0, pin_s3_reg};
    wire prof_chg_w = (pin_s2_reg == pin_s3_reg) && (prof_want_w != prof_reg);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            pin_s3_reg <= 1'b0;
            prof_reg <= '0;
            ftw_reg <= '0;
            phase_reg <= '0;
        end else begin
            pin_s1_reg <= prof_pin_i;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (prof_chg_w) begin
                prof_reg <= prof_want_w;
            end
            ftw_reg <= carrier_ftw_i[prof_reg];
            phase_reg <= phase_reg + ftw_reg;
        end
    end
    assign prof_o = prof_reg;

    // ************************************************************
    // master clock divider
    // ************************************************************
    logic [1:0] mdiv_reg;
    logic mclk_reg;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mdiv_reg <= '0;
            mclk_reg <= 1'b0;
        end else begin
            mdiv_reg <= mdiv_reg + 2'h1;
            mclk_reg <= (mdiv_reg == txo_pkg::MCLK_HALF) ? 1'b1 :
                        (mdiv_reg == 2'h3) ? 1'b0 : mclk_reg;
        end
    end
    assign mclk_o = mclk_reg;

    // ************************************************************
    // hold, fixed delay line, attenuate, modulate, gain
    // ************************************************************
    txo_pkg::txo_iq_t hold_reg, att_reg;
    txo_pkg::txo_iq_t dly_reg [txo_pkg::DLY_DEPTH];
    logic [txo_pkg::LAT_CYC-1:0] vld_sr_reg;
    logic signed [11:0] mod_reg, dac_reg;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_reg <= '0;
            vld_sr_reg <= '0;
        end else begin
            if (iq_valid_i) begin
                hold_reg <= iq_i;
            end
            vld_sr_reg <= {vld_sr_reg[txo_pkg::LAT_CYC-2:0], iq_valid_i};
        end
    end

    // each delay entry has exactly one driving process
    wire txo_pkg::txo_iq_t dly_in_w [txo_pkg::DLY_DEPTH];
    genvar k;
    generate
        for (k = 0; k < txo_pkg::DLY_DEPTH; k++) begin : g_dly
            if (k == 0) begin : g_head
                assign dly_in_w[k] = hold_reg;
            end else begin : g_link
                assign dly_in_w[k] = dly_reg[k-1];
            end
            always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    dly_reg[k] <= '0;
                end else begin
                    dly_reg[k] <= dly_in_w[k];
                end
            end
        end
    endgenerate

    wire txo_pkg::txo_iq_t dly_out_w = dly_reg[txo_pkg::DLY_DEPTH-1];
    wire signed [21:0] att_i_w = dly_out_w.i * $signed(txo_pkg::ATT_NUM);
    wire signed [21:0] att_q_w = dly_out_w.q * $signed(txo_pkg::ATT_NUM);
    wire [3:0] ph_w = phase_reg[txo_pkg::FTW_W-1 -: 4];
    wire signed [11:0] cos_w = txo_pkg::txo_cos(ph_w);
    wire signed [11:0] sin_w = txo_pkg::txo_cos(ph_w - txo_pkg::SIN_OFS);
    wire signed [24:0] mix_w = 25'(att_reg.i * cos_w) - 25'(att_reg.q * sin_w);
    wire signed [13:0] mix_s_w = mix_w[24:txo_pkg::MOD_LSB];
    wire signed [11:0] mix_sat_w = (mix_s_w > 14'(txo_pkg::DAC_MAX)) ? txo_pkg::DAC_MAX :
        (mix_s_w < 14'(txo_pkg::DAC_MIN)) ? txo_pkg::DAC_MIN : mix_s_w[11:0];
    wire signed [21:0] gain_w = mod_reg * $signed(txo_pkg::txo_gain(fine_gain_i));

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            att_reg <= '0;
            mod_reg <= '0;
            dac_reg <= '0;
        end else begin
            att_reg.i <= att_i_w[txo_pkg::ATT_LSB +: 12];
            att_reg.q <= att_q_w[txo_pkg::ATT_LSB +: 12];
            mod_reg <= mix_sat_w;
            dac_reg <= gain_w[txo_pkg::GAIN_LSB +: 12];
        end
    end
    assign dac_code_o = dac_reg;
    assign dac_stb_o = vld_sr_reg[txo_pkg::LAT_CYC-1];

    // ************************************************************
    // cable driver three-wire writer
    // ************************************************************
    txo_pkg::txo_ca_st_t ca_st_reg;
    txo_pkg::txo_ca_t ca_reg;
    logic [txo_pkg::CA_W-1:0] ca_sent_reg, ca_sh_reg;
    logic [4:0] ca_cnt_reg;
    logic ca_pend_reg;
    wire [txo_pkg::CA_W-1:0] ca_sel_w = ca_gain_i[prof_reg];
    wire ca_start_w = (ca_st_reg == txo_pkg::CA_IDLE) &&
                      (ca_pend_reg || (ca_sel_w != ca_sent_reg));
    wire ca_bit_end_w = (ca_cnt_reg[1:0] == 2'h3);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ca_st_reg <= txo_pkg::CA_IDLE;
            ca_reg <= '{en_b: 1'b1, clk: 1'b0, data: 1'b0};
            ca_sent_reg <= '0;
            ca_sh_reg <= '0;
            ca_cnt_reg <= '0;
            ca_pend_reg <= 1'b1;
        end else begin
            case (ca_st_reg)
                txo_pkg::CA_IDLE: begin
                    if (ca_start_w) begin
                        ca_st_reg <= txo_pkg::CA_SHIFT;
                        ca_sent_reg <= ca_sel_w;
                        ca_sh_reg <= ca_sel_w;
                        ca_cnt_reg <= '0;
                        ca_pend_reg <= 1'b0;
                        ca_reg.en_b <= 1'b0;
                        ca_reg.data <= ca_sel_w[txo_pkg::CA_W-1];
                    end
                end
                txo_pkg::CA_SHIFT: begin
                    ca_cnt_reg <= ca_cnt_reg + 5'h1;
                    ca_reg.clk <= (ca_cnt_reg[1:0] == 2'h0) || (ca_cnt_reg[1:0] == 2'h1);
                    if (ca_bit_end_w) begin
                        ca_sh_reg <= {ca_sh_reg[txo_pkg::CA_W-2:0], 1'b0};
                        ca_reg.data <= ca_sh_reg[txo_pkg::CA_W-2];
                    end
                    if (ca_cnt_reg == txo_pkg::CA_LAST) begin
                        ca_st_reg <= txo_pkg::CA_IDLE;
                        ca_reg <= '{en_b: 1'b1, clk: 1'b0, data: 1'b0};
                    end
                end
                default: ca_st_reg <= txo_pkg::CA_IDLE;
            endcase
        end
    end
    assign ca_o = ca_reg;

    // ************************************************************
    // checks
    // ************************************************************
    logic [7:0] hold_age_reg;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_age_reg <= '0;
        end else if (iq_valid_i && (iq_i != hold_reg)) begin
            hold_age_reg <= '0;
        end else if (hold_age_reg != 8'hFF) begin
            hold_age_reg <= hold_age_reg + 8'h1;
        end
    end
    wire signed [21:0] hold_att_w = hold_reg.i * $signed(txo_pkg::ATT_NUM);
    wire [txo_pkg::PROF_W-1:0] prof_pin_want_w = prof_sel_i ^ {1'b0, prof_pin_i};

    sequence s_mclk_high;
        mclk_o ##1 mclk_o ##1 !mclk_o;
    endsequence
    sequence s_ca_frame;
        (!ca_o.en_b)[*8] ##25 ca_o.en_b;
    endsequence

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_atten_bound: assert property ((att_reg.i <= 12'sh5A8) && (att_reg.i >= -12'sh5A8))
        else $error("attenuated I exceeds 3 dB bound");
    a_latency_exact: assert property (iq_valid_i |-> ##119 dac_stb_o)
        else $error("sample did not reach DAC after 119 cycles");
    a_dc_settle: assert property ((hold_age_reg >= 8'hAF) |->
        (att_reg.i == hold_att_w[txo_pkg::ATT_LSB +: 12]))
        else $error("constant input not settled within 176 cycles");
    a_mclk_period: assert property ($rose(mclk_o) |-> ##4 $rose(mclk_o))
        else $error("master clock not four system clocks");
    a_mclk_duty: assert property ($rose(mclk_o) |-> s_mclk_high)
        else $error("master clock high phase wrong");
    a_prof_follow: assert property (($stable(prof_pin_i) && $stable(prof_sel_i))[*5] |->
        prof_o == prof_pin_want_w)
        else $error("profile does not follow pin");
    a_hop_time: assert property ((prof_chg_w ##1 $stable(prof_sel_i)) |->
        ##1 (ftw_reg == carrier_ftw_i[prof_o]))
        else $error("carrier switch too slow");
    a_gain_unity: assert property ((fine_gain_i == 4'hF) |=> dac_code_o == $past(mod_reg))
        else $error("top fine gain code not unity");
    a_ca_frame: assert property ($fell(ca_o.en_b) |-> s_ca_frame)
        else $error("cable driver frame length wrong");
    a_prof_sample: assert property ($changed(prof_o) |->
        $past(pin_s2_reg) == $past(pin_s3_reg))
        else $error("profile changed on unsettled pin");
    a_lat_profile: assert property (dac_stb_o |-> $past(iq_valid_i, 119))
        else $error("latency varied");
endmodule : txo_output_stage

/* testbench/txo_modem_model.sv */
// Purpose: baseband modem model feeding I/Q samples to the output stage
// Assumes: samples launched on the falling edge of the system clock
// Notes: between samples the iq lines invert their last word every cycle
`timescale 1ns/10ps
module txo_modem_model (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic dc_mode_i,
    input wire txo_pkg::txo_iq_t dc_i,
    output logic iq_valid_o,
    output txo_pkg::txo_iq_t iq_o
);
    integer seed = 32'hc40e;
    initial begin
        iq_valid_o = 1'b0;
        iq_o = '0;
    end
    // ************************************************************
    // one sample per cycle while requested, i and q in one word
    // ************************************************************
    always @(negedge sys_clk_i) begin
        iq_valid_o <= req_i && rst_b_i;
        if (!(req_i && rst_b_i)) begin
            iq_o <= ~iq_o;
        end else if (dc_mode_i) begin
            iq_o <= dc_i;
        end else begin
            iq_o <= 24'($random(seed));
        end
    end
endmodule : txo_modem_model

/* testbench/txo_output_stage_tb.sv */
// Purpose: self-checking bench for the transmit output stage
// Assumes: design inputs change on the falling clock edge
// Notes: strobe times and cable words are queued and compared on arrival
`timescale 1ns/10ps
module txo_output_stage_tb;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic prof_pin_i = 1'b0;
    logic [txo_pkg::PROF_W-1:0] prof_sel_i = '0;
    logic [txo_pkg::GAIN_W-1:0] fine_gain_i = 4'hF;
    logic [txo_pkg::NPROF-1:0][txo_pkg::FTW_W-1:0] carrier_ftw_i;
    logic [txo_pkg::NPROF-1:0][txo_pkg::CA_W-1:0] ca_gain_i;
    logic req = 1'b0;
    logic dc_mode = 1'b1;
    logic stream_on = 1'b0;
    txo_pkg::txo_iq_t iq_i;
    txo_pkg::txo_iq_t dc_iq = {12'h7FF, 12'h7FF};
    logic iq_valid_i;
    logic signed [txo_pkg::IQ_W-1:0] dac_code_o;
    logic dac_stb_o;
    logic mclk_o;
    logic [txo_pkg::PROF_W-1:0] prof_o;
    txo_pkg::txo_ca_t ca_o;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    int mrun = 0;
    int calow = 0;
    int dc_exp = 0;
    integer seed = 32'hc40e;
    int stb_q[$];
    logic [7:0] ca_q[$];
    logic [7:0] caw = '0;
    logic [7:0] last_gain;
    logic mlast = 1'b0;
    logic mseen = 1'b0;
    logic caclk = 1'b0;

    txo_modem_model txo_modem_model_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_i(req),
        .dc_mode_i(dc_mode), .dc_i(dc_iq), .iq_valid_o(iq_valid_i), .iq_o(iq_i));
    txo_output_stage txo_output_stage_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .iq_valid_i(iq_valid_i), .iq_i(iq_i), .prof_pin_i(prof_pin_i), .prof_sel_i(prof_sel_i),
        .carrier_ftw_i(carrier_ftw_i), .ca_gain_i(ca_gain_i), .fine_gain_i(fine_gain_i),
        .dac_code_o(dac_code_o), .dac_stb_o(dac_stb_o), .mclk_o(mclk_o), .prof_o(prof_o),
        .ca_o(ca_o));

    task automatic check(input string what, input logic signed [31:0] seen, exp, input int tol);
        logic bad;
        bad = (tol == 0) ? (seen !== exp) : ($isunknown(seen) || seen - exp > tol
            || exp - seen > tol);
        comparisons++;
        if (bad) begin
            mismatches++;
            $display("wrong value %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // ************************************************************
    // monitors: strobe latency, master clock, cable driver frames
    // ************************************************************
    initial forever #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (rst_b_i && iq_valid_i === 1'b1) stb_q.push_back(cyc + txo_pkg::LAT_CYC);
        if (dac_stb_o === 1'b1) begin
            check("dac_stb_cycle", cyc, stb_q.size() > 0 ? stb_q.pop_front() : -1, 0);
        end
        if (!rst_b_i || mclk_o === mlast) begin
            mrun++;
        end else begin
            if (mseen) check("mclk_half", mrun, 2, 0);
            mseen = 1'b1;
            mrun = 1;
        end
        mlast = mclk_o;
        if (rst_b_i && ca_o.en_b === 1'b0) begin
            calow++;
            if (ca_o.clk === 1'b1 && caclk === 1'b0) caw = {caw[6:0], ca_o.data};
        end else if (calow > 0) begin
            check("ca_len", calow, 32, 0);
            check("ca_word", caw, ca_q.size() > 0 ? ca_q.pop_front() : -1, 0);
            calow = 0;
        end
        caclk = ca_o.clk;
    end
    always @(posedge sys_clk_i) if (stream_on) req <= $random(seed) & 1;

    task automatic hop(input logic [1:0] sel, input logic pin);
        logic [1:0] want;
        logic [1:0] old;
        int n;
        want = sel ^ {1'b0, pin};
        old = prof_o;
        n = 0;
        @(negedge sys_clk_i);
        if (ca_gain_i[want] != last_gain) ca_q.push_back(ca_gain_i[want]);
        last_gain = ca_gain_i[want];
        prof_sel_i = sel;
        if (pin != prof_pin_i) begin
            prof_pin_i = pin;
            repeat (3) @(posedge sys_clk_i);
            #1 check("prof_early", prof_o, old, 0);
            @(posedge sys_clk_i);
            #1 check("prof_pin", prof_o, want, 0);
        end else begin
            while (prof_o !== want && n < 232) begin
                @(posedge sys_clk_i);
                #1 n++;
            end
            check("prof_sel", prof_o, want, 0);
        end
        repeat (300) @(negedge sys_clk_i);
    endtask : hop

    initial begin
        for (int p = 0; p < txo_pkg::NPROF; p++) begin
            carrier_ftw_i[p] = (p == 0) ? '0 : 26'($random(seed));
            ca_gain_i[p] = 8'($random(seed));
        end
        ca_q.push_back(ca_gain_i[0]);
        last_gain = ca_gain_i[0];
        repeat (6) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        // full-scale dc on both components, zero carrier
        for (int g = 0; g < 16; g += 7) begin
            @(negedge sys_clk_i);
            fine_gain_i = 4'(g + (g / 14));
            @(posedge sys_clk_i) req <= 1'b1;
            @(posedge sys_clk_i) req <= 1'b0;
            repeat (177) @(posedge sys_clk_i);
            for (int r = 0; r < 2; r++) begin
                #1 dc_exp = $rtoi(2047.0 / $sqrt(2.0)
                    * $pow(10.0, (-7.5 + 0.5 * fine_gain_i) / 20.0));
                check("dac_dc", dac_code_o, dc_exp, 6);
                repeat (40) @(posedge sys_clk_i);
            end
        end
        dc_mode = 1'b0;
        stream_on = 1'b1;
        hop(2'h0, 1'b1);
        hop(2'h2, 1'b1);
        hop(2'h2, 1'b0);
        hop(2'h0, 1'b0);
        stream_on = 1'b0;
        @(posedge sys_clk_i) req <= 1'b0;
        repeat (300) @(posedge sys_clk_i);
        check("stb_left", stb_q.size(), 0, 0);
        check("ca_left", ca_q.size(), 0, 0);
        conclude();
    end
    initial begin
        repeat (30000) @(posedge sys_clk_i);
        mismatches++;
        conclude();
    end
endmodule : txo_output_stage_tb
